// File: core/asrf_defs.svh
// Offsets, field positions, reset values and timing counts
// Assumes a 25 MHz system clock
`ifndef ASRF_DEFS_SVH
`define ASRF_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ASRF_OFS_CTRL0 2'h0
`define ASRF_OFS_CTRL1 2'h1
`define ASRF_OFS_STAT  2'h2
`define ASRF_OFS_DATA  2'h3

// ****************************************
// Field positions and reset values
// ****************************************
`define ASRF_MODE_BIT  1
`define ASRF_CHN_LSB   3
`define ASRF_FRST_BIT  0
`define ASRF_TRIG_LSB  2
`define ASRF_FMT_BIT   7
`define ASRF_CTRL_RST  10'h000

// ****************************************
// Timing
// ****************************************
`define ASRF_CLK_NS    40
`define ASRF_OSC_NS    160
`define ASRF_OSC_CYC   ((`ASRF_OSC_NS) / (`ASRF_CLK_NS))
`define ASRF_PIPE_TICK 5

`endif

// File: core/asrf_pkg.sv
// Types shared by the sequencer and its users
// Assumes asrf_defs.svh for numeric constants
`default_nettype none

package asrf_pkg;

	// Register port request
	typedef struct packed {
		logic [1:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} asrf_req_t;

	// Single-conversion sequencer
	typedef enum logic [1:0] {
		ASRF_IDLE = 2'b00,
		ASRF_PIPE = 2'b01,
		ASRF_CONV = 2'b10
	} asrf_state_t;

endpackage

`default_nettype wire

// File: core/asrf_top.sv
// Conversion sequencer with 16-word circular result FIFO
// Assumes pins arrive unsynchronised; converter result is on clk
`timescale 1ns/1ps
`default_nettype none
`include "asrf_defs.svh"

// Function
// RULE_01 - Control word 0 bit 1 set selects single conversion mode.
// RULE_02 - Start falling edge holds all selected inputs and starts converting.
// RULE_03 - Single mode timed by internal oscillator, not external clock.
// RULE_04 - Data-available asserted only after samples are stored in FIFO.
// RULE_05 - Single mode samples one to four channels together.
// RULE_06 - With trigger equal n, strobe after pipeline plus n oscillator periods.
// RULE_07 - Oscillator stopped in continuous mode.
// RULE_08 - Mode bit 0 gives continuous mode on free-running host clock.
// RULE_09 - Continuous mode writes one value per conversion clock rising edge.
// RULE_10 - Host keeps continuous throughput within rated per-channel rates.
// RULE_11 - Multiple channels written in fixed repeating channel order.
// RULE_12 - Results delivered as straight binary or two's complement.
// RULE_13 - Two's complement flips the MSB of the binary code.
// RULE_14 - FIFO holds at most 16 words.
// RULE_15 - Read pointer addresses the next word delivered.
// RULE_16 - Write pointer addresses the last written word.
// RULE_17 - Trigger met when new writes equal the trigger level.
// RULE_18 - Host reads exactly trigger-level words per strobe.
// RULE_19 - First word of each block is the first scanned channel.
// RULE_20 - Trigger level chosen by control word, set depends on channels.
// RULE_21 - One channel allows trigger levels 1, 4, 8 or 14.
// RULE_22 - Data-available is a low-going pulse.
// RULE_23 - Read is both chip selects combined with read strobe.
// RULE_24 - Read pointer advances per read; pointers wrap at 16.
// RULE_25 - Reset clears pointers, empties FIFO, strobe inactive.
module asrf_top
	import asrf_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Register port
	input  wire asrf_pkg::asrf_req_t req,
	output var  logic [15:0]       rdata,
	// Conversion pins
	input  wire logic              conversion_start_n,
	input  wire logic              conversion_clock_in,
	// Parallel read pins
	input  wire logic              chip_select_low_n,
	input  wire logic              chip_select_high,
	input  wire logic              read_n,
	output var  logic [11:0]       read_data,
	output var  logic              data_available_n,
	// Converter core
	input  wire logic [11:0]       conv_result,
	output var  logic              hold_n,
	output var  logic [1:0]        conv_channel,
	output var  logic              osc_run
);
	import asrf_pkg::*;

	localparam logic [2:0] OSC_LAST = 3'(`ASRF_OSC_CYC - 1);
	localparam logic [2:0] PIPE_LAST = 3'(`ASRF_PIPE_TICK - 1);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [4:0] pin_s1;
	logic [4:0] pin_s2;
	logic [4:0] pin_s3;
	logic [4:0] pin_raw;

	assign pin_raw = {conversion_start_n, conversion_clock_in,
		chip_select_low_n, chip_select_high, read_n};

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++)
		begin : g_sync
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					pin_s1[gi] <= 1'b1;
					pin_s2[gi] <= 1'b1;
					pin_s3[gi] <= 1'b1;
				end
				else
				begin
					pin_s1[gi] <= pin_raw[gi];
					pin_s2[gi] <= pin_s1[gi];
					pin_s3[gi] <= pin_s2[gi];
				end
			end
		end
	endgenerate

	logic start_fall;
	logic cclk_rise;
	logic rd_act;
	logic rd_act_q;
	logic pin_pop;

	assign start_fall = pin_s3[4] & ~pin_s2[4];
	assign cclk_rise = ~pin_s3[3] & pin_s2[3];
	assign rd_act = ~pin_s2[2] & pin_s2[1] & ~pin_s2[0]; // RULE_23
	assign rd_act_q = ~pin_s3[2] & pin_s3[1] & ~pin_s3[0];
	assign pin_pop = rd_act & ~rd_act_q;

	// ****************************************
	// State
	// ****************************************
	logic [9:0]  ctrl0;
	logic [9:0]  ctrl1;
	asrf_state_t state;
	logic [2:0]  osc_cnt;
	logic [2:0]  tick_cnt;
	logic [1:0]  ch;
	logic [3:0]  rd_ptr;
	logic [3:0]  wr_ptr;
	logic [3:0]  trig_ptr;
	logic [4:0]  fill;
	logic [4:0]  new_cnt;
	logic [11:0] mem [16];

	logic [9:0]  next_ctrl0;
	logic [9:0]  next_ctrl1;
	asrf_state_t next_state;
	logic [2:0]  next_osc_cnt;
	logic [2:0]  next_tick_cnt;
	logic [1:0]  next_ch;
	logic [3:0]  next_rd_ptr;
	logic [3:0]  next_wr_ptr;
	logic [3:0]  next_trig_ptr;
	logic [4:0]  next_fill;
	logic [4:0]  next_new_cnt;
	logic        next_av_n;
	logic        next_hold_n;
	logic        next_osc_run;
	logic [11:0] next_read_data;
	logic [15:0] next_rdata;

	logic       single;
	logic [1:0] nch;
	logic [1:0] trig_code;
	logic       twos;
	logic [4:0] level;
	logic       tick;
	logic       wr_en;
	logic       pop;
	logic       do_pop;
	logic       flush;
	logic [11:0] head;

	assign single = ctrl0[`ASRF_MODE_BIT]; // RULE_01 RULE_08
	assign nch = ctrl0[`ASRF_CHN_LSB +: 2];
	assign trig_code = ctrl1[`ASRF_TRIG_LSB +: 2];
	assign twos = ctrl1[`ASRF_FMT_BIT];
	assign tick = osc_run && (osc_cnt == OSC_LAST);
	assign head = mem[rd_ptr];

	// Allowed trigger levels per channel count
	function automatic logic [4:0] trig_lvl(input logic [1:0] n,
		input logic [1:0] c);
		logic [4:0] v;
		v = 5'h01;
		unique case ({n, c})
			4'h0: v = 5'h01; // RULE_21
			4'h1: v = 5'h04;
			4'h2: v = 5'h08;
			4'h3: v = 5'h0E;
			4'h4: v = 5'h02;
			4'h5: v = 5'h04;
			4'h6: v = 5'h08;
			4'h7: v = 5'h0C;
			4'h8: v = 5'h03;
			4'h9: v = 5'h06;
			4'hA: v = 5'h09;
			4'hB: v = 5'h0C;
			4'hC: v = 5'h04;
			4'hD: v = 5'h08;
			4'hE: v = 5'h0C;
			4'hF: v = 5'h10;
		endcase
		return v;
	endfunction

	assign level = trig_lvl(nch, trig_code); // RULE_20

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb
	begin
		next_ctrl0 = ctrl0;
		next_ctrl1 = ctrl1;
		next_state = state;
		next_osc_cnt = 3'h0;
		next_tick_cnt = tick_cnt;
		next_ch = ch;
		next_rd_ptr = rd_ptr;
		next_wr_ptr = wr_ptr;
		next_trig_ptr = trig_ptr;
		next_fill = fill;
		next_new_cnt = new_cnt;
		next_av_n = 1'b1;
		next_hold_n = 1'b1;
		next_read_data = read_data;
		next_rdata = 16'h0000;
		wr_en = 1'b0;
		flush = 1'b0;
		pop = pin_pop;

		// Register port
		if (req.wr)
		begin
			unique case (req.addr)
				`ASRF_OFS_CTRL0:
				begin
					next_ctrl0 = req.wdata[9:0];
					flush = 1'b1;
				end
				`ASRF_OFS_CTRL1:
				begin
					next_ctrl1 = req.wdata[9:0];
					next_ctrl1[`ASRF_FRST_BIT] = 1'b0;
					flush = req.wdata[`ASRF_FRST_BIT];
				end
				default:
				begin
				end
			endcase
		end
		if (req.rd)
		begin
			unique case (req.addr)
				`ASRF_OFS_CTRL0: next_rdata = {6'h00, ctrl0};
				`ASRF_OFS_CTRL1: next_rdata = {6'h00, ctrl1};
				`ASRF_OFS_STAT:
					next_rdata = {1'b0, rd_ptr, wr_ptr, fill,
						state != ASRF_IDLE, single};
				`ASRF_OFS_DATA:
				begin
					next_rdata = {4'h0, twos ? {~head[11], head[10:0]} : head};
					pop = 1'b1;
				end
			endcase
		end

		// Oscillator runs only for a single conversion
		if (osc_run)
			next_osc_cnt = (osc_cnt == OSC_LAST) ? 3'h0 : osc_cnt + 3'h1; // RULE_03

		// Conversion sequencing
		unique case (state)
			ASRF_IDLE:
			begin
				if (single && start_fall)
				begin
					next_hold_n = 1'b0; // RULE_02
					next_state = ASRF_PIPE;
					next_tick_cnt = 3'h0;
					next_ch = 2'h0;
				end
				else if (!single && cclk_rise)
				begin
					wr_en = 1'b1; // RULE_09
					next_ch = (ch == nch) ? 2'h0 : ch + 2'h1; // RULE_11
				end
			end
			ASRF_PIPE:
			begin
				if (tick)
				begin
					next_tick_cnt = tick_cnt + 3'h1;
					if (tick_cnt == PIPE_LAST)
						next_state = ASRF_CONV; // RULE_06
				end
			end
			ASRF_CONV:
			begin
				if (tick)
				begin
					wr_en = 1'b1; // RULE_05
					next_ch = (ch == nch) ? 2'h0 : ch + 2'h1;
					if (ch == nch)
						next_state = ASRF_IDLE;
				end
			end
			default: next_state = ASRF_IDLE;
		endcase
		if (!single)
			next_state = ASRF_IDLE;
		next_osc_run = single && (next_state != ASRF_IDLE); // RULE_07

		// FIFO pointers
		do_pop = pop && (fill != 5'h00);
		if (do_pop)
		begin
			next_read_data = twos ? {~head[11], head[10:0]} : head; // RULE_12 RULE_13
			next_rd_ptr = rd_ptr + 4'h1; // RULE_15 RULE_24
		end
		if (wr_en)
		begin
			next_wr_ptr = wr_ptr + 4'h1; // RULE_16
			next_new_cnt = new_cnt + 5'h01;
			if (fill == 5'h10 && !do_pop)
				next_rd_ptr = rd_ptr + 4'h1;
		end
		next_fill = fill + {4'h0, wr_en && !(fill == 5'h10 && !do_pop)}
			- {4'h0, do_pop}; // RULE_14
		if (wr_en && next_new_cnt == level)
		begin
			next_av_n = 1'b0; // RULE_04 RULE_17 RULE_22
			next_new_cnt = 5'h00;
			next_trig_ptr = next_wr_ptr;
		end

		// Restart scan so blocks begin at the first channel
		if (flush)
		begin
			next_state = ASRF_IDLE;
			next_osc_run = 1'b0;
			next_ch = 2'h0; // RULE_19
			next_rd_ptr = 4'h0;
			next_wr_ptr = 4'hF;
			next_trig_ptr = 4'hF;
			next_fill = 5'h00;
			next_new_cnt = 5'h00;
			next_av_n = 1'b1;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ctrl0 <= `ASRF_CTRL_RST;
			ctrl1 <= `ASRF_CTRL_RST;
			state <= ASRF_IDLE;
			osc_cnt <= 3'h0;
			tick_cnt <= 3'h0;
			ch <= 2'h0;
			rd_ptr <= 4'h0; // RULE_25
			wr_ptr <= 4'hF;
			trig_ptr <= 4'hF;
			fill <= 5'h00;
			new_cnt <= 5'h00;
			data_available_n <= 1'b1;
			hold_n <= 1'b1;
			osc_run <= 1'b0;
			read_data <= 12'h000;
			rdata <= 16'h0000;
		end
		else
		begin
			ctrl0 <= next_ctrl0;
			ctrl1 <= next_ctrl1;
			state <= next_state;
			osc_cnt <= next_osc_cnt;
			tick_cnt <= next_tick_cnt;
			ch <= next_ch;
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
			trig_ptr <= next_trig_ptr;
			fill <= next_fill;
			new_cnt <= next_new_cnt;
			data_available_n <= next_av_n;
			hold_n <= next_hold_n;
			osc_run <= next_osc_run;
			read_data <= next_read_data;
			rdata <= next_rdata;
		end
	end

	// Result storage at location after last write
	always_ff @(posedge clk)
	begin
		if (wr_en && !flush)
			mem[wr_ptr + 4'h1] <= conv_result;
	end

	assign conv_channel = ch;

	// ****************************************
	// Assertions
	// ****************************************
	a_av_pulse_one: assert property (@(posedge clk) disable iff (rst) // RULE_22
		!data_available_n |=> data_available_n)
		else $error("data available held longer than one cycle");

	a_av_after_write: assert property (@(posedge clk) disable iff (rst) // RULE_04
		$fell(data_available_n) |-> $past(wr_en) && fill != 5'h00)
		else $error("data available without a stored sample");

	a_osc_off_cont: assert property (@(posedge clk) disable iff (rst) // RULE_07
		!single |=> !osc_run && osc_cnt == 3'h0)
		else $error("oscillator running in continuous mode");

	a_osc_tick_gap: assert property (@(posedge clk) disable iff (rst) // RULE_03
		tick |=> !tick [*3])
		else $error("oscillator ticks too close");

	a_start_hold: assert property (@(posedge clk) disable iff (rst) // RULE_02
		state == ASRF_IDLE && single && start_fall && !req.wr
		|=> !hold_n && state == ASRF_PIPE)
		else $error("start edge did not hold inputs");

	a_cont_write: assert property (@(posedge clk) disable iff (rst) // RULE_09
		!single && cclk_rise && !req.wr |=> wr_ptr == $past(wr_ptr) + 4'h1)
		else $error("conversion clock edge wrote no value");

	a_read_advance: assert property (@(posedge clk) disable iff (rst) // RULE_24
		pin_pop && fill != 5'h00 && !wr_en && !req.wr
		|=> rd_ptr == $past(rd_ptr) + 4'h1 && fill == $past(fill) - 5'h01)
		else $error("read did not advance pointer");

	a_fill_max: assert property (@(posedge clk) disable iff (rst) // RULE_14
		fill <= 5'h10)
		else $error("fifo fill above 16");

	a_chan_order: assert property (@(posedge clk) disable iff (rst) // RULE_11
		wr_en && !flush |=> ch == (($past(ch) == nch) ? 2'h0 : $past(ch) + 2'h1))
		else $error("channel order broken");

	a_fmt_twos: assert property (@(posedge clk) disable iff (rst) // RULE_13
		do_pop && twos && !req.wr |=> read_data == {~$past(head[11]), $past(head[10:0])})
		else $error("two's complement coding wrong");

endmodule

`default_nettype wire

// File: testbench/asrf_host_model.sv
// Host model: free-running conversion clock and block reads on strobe
// Assumes a device whose pin reads land 3 clocks after assertion
`timescale 1ns/1ps
`default_nettype none

module asrf_host_model
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Scenario control
	input  wire logic        auto_rd,
	input  wire logic        clk_en,
	input  wire logic [4:0]  level,
	// Device pins
	input  wire logic        data_available_n,
	input  wire logic [11:0] read_data,
	output var  logic        chip_select_low_n,
	output var  logic        chip_select_high,
	output var  logic        read_n,
	output var  logic        conversion_clock_in
);
	logic [11:0] got [0:15];
	int          got_n;
	logic [1:0]  div;

	initial
	begin
		chip_select_low_n = 1'b1;
		chip_select_high = 1'b0;
		read_n = 1'b1;
		conversion_clock_in = 1'b0;
		got_n = 0;
		div = 2'h0;
	end

	// ****************************************
	// Conversion clock, 8 system clocks a period
	// ****************************************
	always @(posedge clk)
	begin
		div <= clk_en ? div + 2'h1 : 2'h0;
		if (!clk_en)
			conversion_clock_in <= 1'b0;
		else if (div == 2'h3)
			conversion_clock_in <= ~conversion_clock_in;
	end

	// ****************************************
	// One block of level words per strobe
	// ****************************************
	initial forever
	begin
		@(posedge clk);
		if (auto_rd && data_available_n === 1'b0 && rst === 1'b0)
		begin
			for (int k = 0; k < level; k++)
			begin
				chip_select_low_n <= 1'b0;
				chip_select_high <= 1'b1;
				read_n <= 1'b0;
				repeat (4) @(posedge clk);
				got[got_n % 16] = read_data;
				got_n++;
				chip_select_low_n <= 1'b1;
				chip_select_high <= 1'b0;
				read_n <= 1'b1;
				repeat (3) @(posedge clk);
			end
		end
	end
endmodule
`default_nettype wire

// File: testbench/asrf_top_test.sv
// Self-checking bench for the sequencer and result FIFO
// Assumes asrf_pkg compiled and the host model beside it
`timescale 1ns/1ps
`default_nettype none

module asrf_top_test;
	import asrf_pkg::*;

	logic        clk;
	logic        rst;
	asrf_req_t   req;
	logic [15:0] rdata;
	logic        conversion_start_n;
	logic        conversion_clock_in;
	logic        chip_select_low_n;
	logic        chip_select_high;
	logic        read_n;
	logic [11:0] read_data;
	logic        data_available_n;
	logic [11:0] conv_result;
	logic        hold_n;
	logic [1:0]  conv_channel;
	logic        osc_run;
	logic        auto_rd;
	logic        clk_en;
	logic [4:0]  level;
	logic [9:0]  tag_hi;
	int          bad_count;
	int          checks;
	int          cyc;
	int          edges;
	int          osc_n;
	int          hold_cnt;
	logic        prev;
	logic [15:0] s;

	// Converter core stand-in tags each sample with its channel
	assign conv_result = {tag_hi, conv_channel};

	asrf_top dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
		.conversion_start_n(conversion_start_n), .conversion_clock_in(conversion_clock_in),
		.chip_select_low_n(chip_select_low_n), .chip_select_high(chip_select_high),
		.read_n(read_n), .read_data(read_data), .data_available_n(data_available_n),
		.conv_result(conv_result), .hold_n(hold_n), .conv_channel(conv_channel),
		.osc_run(osc_run));

	asrf_host_model host (.clk(clk), .rst(rst), .auto_rd(auto_rd), .clk_en(clk_en),
		.level(level), .data_available_n(data_available_n), .read_data(read_data),
		.chip_select_low_n(chip_select_low_n), .chip_select_high(chip_select_high),
		.read_n(read_n), .conversion_clock_in(conversion_clock_in));

	// ****************************************
	// Clock, compares, bus tasks
	// ****************************************
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic chk16(input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic chk12(input logic [11:0] e, input logic [11:0] g);
		checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic wait_got(input int n);
		cyc = 0;
		while (host.got_n < n && cyc < 400)
		begin
			@(posedge clk);
			cyc++;
		end
		chk16(16'(n), 16'(host.got_n));
	endtask

	// Counts conversion clock rises and system clocks with the oscillator running until stop
	task automatic run_clk(input int max_edges, input bit stop_av);
		edges = 0;
		osc_n = 0;
		prev = 1'b0;
		clk_en <= 1'b1;
		cyc = 0;
		while ((data_available_n !== 1'b0 || !stop_av) && edges < max_edges && cyc < 3000)
		begin
			@(posedge clk);
			#1;
			cyc++;
			edges += (conversion_clock_in && !prev);
			osc_n += (osc_run === 1'b1);
			prev = conversion_clock_in;
		end
		@(posedge clk);
		clk_en <= 1'b0;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_reset;
		reg_rd(2'h2, s);
		chk16(16'h0780, s);
		chk16(16'h0003, {13'h0, osc_run, data_available_n, hold_n});
	endtask

	task automatic test_single(input int n);
		reg_wr(2'h0, 16'h0002 | 16'((n - 1) << 3));
		reg_wr(2'h1, 16'h0000);
		level <= 5'(n);
		tag_hi <= 10'h2A0;
		auto_rd <= 1'b1;
		host.got_n = 0;
		repeat (3) @(posedge clk);
		conversion_start_n <= 1'b0;
		cyc = 0;
		hold_cnt = 0;
		osc_n = 0;
		while (data_available_n !== 1'b0 && cyc < 200)
		begin
			@(posedge clk);
			if (cyc == 2)
				conversion_start_n <= 1'b1;
			#1;
			cyc++;
			hold_cnt += (hold_n === 1'b0);
			osc_n += (osc_run === 1'b1);
		end
		chk16(16'h0001, 16'(cyc >= (5 + n) * 4 && cyc <= (5 + n) * 4 + 6));
		chk16(16'h0001, 16'(hold_cnt));
		chk16(16'((5 + n) * 4), 16'(osc_n));
		wait_got(n);
		for (int k = 0; k < n; k++)
			chk12({10'h2A0, 2'(k)}, host.got[k]);
	endtask

	task automatic test_trigger;
		int lv [4] = '{1, 4, 8, 14};
		for (int c = 0; c < 4; c++)
		begin
			reg_wr(2'h0, 16'h0000);
			reg_wr(2'h1, 16'(c << 2));
			level <= 5'(lv[c]);
			tag_hi <= 10'(c);
			host.got_n = 0;
			run_clk(100, 1'b1);
			chk16(16'(lv[c]), 16'(edges));
			chk16(16'h0000, 16'(osc_n));
			wait_got(lv[c]);
			chk12({10'(c), 2'h0}, host.got[lv[c] - 1]);
		end
	endtask

	task automatic test_format;
		reg_wr(2'h0, 16'h0008);
		reg_wr(2'h1, 16'h0084);
		level <= 5'd4;
		tag_hi <= 10'h3FF;
		host.got_n = 0;
		run_clk(100, 1'b1);
		wait_got(4);
		for (int k = 0; k < 4; k++)
			chk12({10'h3FF, 2'(k % 2)} ^ 12'h800, host.got[k]);
	endtask

	task automatic test_full;
		auto_rd <= 1'b0;
		reg_wr(2'h0, 16'h0000);
		reg_wr(2'h1, 16'h0000);
		level <= 5'd1;
		tag_hi <= 10'h155;
		run_clk(20, 1'b0);
		chk16(16'd20, 16'(edges));
		repeat (12) @(posedge clk);
		reg_rd(2'h2, s);
		chk16(16'h21C0, s & 16'hFFFD);
		reg_rd(2'h3, s);
		chk16(16'h0554, s);
		reg_rd(2'h2, s);
		chk16(16'h29BC, s & 16'hFFFD);
	endtask

	task automatic report_and_stop;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial
	begin
		bad_count = 0;
		checks = 0;
		rst = 1'b1;
		req = '0;
		conversion_start_n = 1'b1;
		tag_hi = 10'h000;
		auto_rd = 1'b0;
		clk_en = 1'b0;
		level = 5'd1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		test_reset();
		for (int n = 1; n <= 4; n++)
			test_single(n);
		test_trigger();
		test_format();
		test_full();
		report_and_stop();
	end

	initial
	begin
		repeat (5000) @(posedge clk);
		bad_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
